// >>> rtl/ifb_regs.svh
`ifndef IFB_REGS_SVH
`define IFB_REGS_SVH

// Byte offsets on the register bus
`define IFB_OFS_FLAGS0 8'h00
`define IFB_OFS_FLAGS1 8'h04
`define IFB_OFS_STAT 8'h08
`define IFB_OFS_MASK 8'h0C

// Implemented flag positions per bank
`define IFB_IMPL0 16'h7FFF
`define IFB_IMPL1 16'hFFDF

// Reserved positions
`define IFB_BIT_RSVD0 15
`define IFB_BIT_RSVD1 5

// Reset values
`define IFB_RST_FLAGS 16'h0000
`define IFB_RST_STAT 32'h0000_0000
`define IFB_RST_MASK 32'h0000_0000

`endif

// >>> rtl/ifb_pkg.sv
package ifb_pkg;

  // Request lines of the first bank, bit 15 first
  typedef struct packed {
    logic spare;
    logic dma_ch1_done_flag;
    logic adc_conv_done_flag;
    logic uart_a_tx_flag;
    logic uart_a_rx_flag;
    logic spi_a_event_flag;
    logic spi_a_error_flag;
    logic timer_c_flag;
    logic timer_b_flag;
    logic out_compare_b_flag;
    logic in_capture_b_flag;
    logic dma_ch0_done_flag;
    logic timer_a_flag;
    logic out_compare_a_flag;
    logic in_capture_a_flag;
    logic ext_pin_a_flag;
  } ifb_req0_t;

  // Request lines of the second bank, bit 15 first
  typedef struct packed {
    logic uart_b_tx_flag;
    logic uart_b_rx_flag;
    logic ext_pin_c_flag;
    logic timer_e_flag;
    logic timer_d_flag;
    logic out_compare_d_flag;
    logic out_compare_c_flag;
    logic dma_ch2_done_flag;
    logic in_capture_h_flag;
    logic in_capture_g_flag;
    logic spare;
    logic ext_pin_b_flag;
    logic change_notify_flag;
    logic comparator_flag;
    logic i2c_master_event_flag;
    logic i2c_slave_event_flag;
  } ifb_req1_t;

  // Both flag registers as one carrier
  typedef struct packed {
    logic [15:0] bank1;
    logic [15:0] bank0;
  } ifb_flags_t;

endpackage

// >>> rtl/ifb_flag_bank.sv
// Behaviour
// - Bank0 14..8: DMA1, ADC, UART A tx/rx, SPI A event/error, timer C.
// - Bank0 7..0: timer B, OC/IC B, DMA0, timer A, OC/IC A, pin A.
// - Bank1 15..8: UART B tx/rx, pin C, timers E/D, OC D/C, DMA2.
// - Bank1 bits 7,6,4,3: IC H, IC G, pin B, change notify.
// - Bank1 bits 2..0: comparator, I2C master, I2C slave.
// - A flag reads 1 once its source requested or a write set it, until a write of 0 clears it.
// - Bank 0 bit 15 and bank 1 bit 5 always read zero.
//
// The Wishbone slave port and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
`include "ifb_regs.svh"

module ifb_flag_bank (
  input wire logic sys_clk, // 40 MHz system clock
  input wire logic rst_n, // Async reset, active low
  input wire ifb_pkg::ifb_req0_t req0, // Bank 0 request lines
  input wire ifb_pkg::ifb_req1_t req1, // Bank 1 request lines
  input wire logic cyc_i, // Wishbone cycle
  input wire logic stb_i, // Wishbone strobe
  input wire logic we_i, // Wishbone write enable
  input wire logic [7:0] adr_i, // Wishbone byte address
  input wire logic [3:0] sel_i, // Wishbone byte selects
  input wire logic [31:0] dat_i, // Wishbone write data
  output logic [31:0] dat_o, // Wishbone read data
  output logic ack_o, // Wishbone acknowledge
  output ifb_pkg::ifb_flags_t flags, // Current flag registers
  output logic irq // Level interrupt
);

  ////////////////////////////////////////////////////////////////////////////
  // Request mapping

  wire [15:0] req0_vec;
  wire [15:0] req1_vec;
  wire [31:0] req_all;

  assign req0_vec = req0 & `IFB_IMPL0;
  assign req1_vec = req1 & `IFB_IMPL1;
  assign req_all = {req1_vec, req0_vec};

  ////////////////////////////////////////////////////////////////////////////
  // Bus decode

  logic ack_reg;
  logic [31:0] dat_reg;
  logic [31:0] dat_next;

  wire req_live;
  wire acc_done;
  wire wr_done;
  wire rd_done;
  wire hit_flags0;
  wire hit_flags1;
  wire hit_stat;
  wire hit_mask;
  wire [31:0] lane_mask;

  assign req_live = cyc_i & stb_i;
  // Write and read-clear act only on the edge that ends the access
  assign acc_done = req_live & ack_reg;
  assign wr_done = acc_done & we_i;
  assign rd_done = acc_done & ~we_i;
  assign hit_flags0 = (adr_i == `IFB_OFS_FLAGS0);
  assign hit_flags1 = (adr_i == `IFB_OFS_FLAGS1);
  assign hit_stat = (adr_i == `IFB_OFS_STAT);
  assign hit_mask = (adr_i == `IFB_OFS_MASK);
  assign lane_mask = {{8{sel_i[3]}}, {8{sel_i[2]}},
                      {8{sel_i[1]}}, {8{sel_i[0]}}};

  ////////////////////////////////////////////////////////////////////////////
  // Flag registers

  logic [15:0] flags0_reg;
  logic [15:0] flags1_reg;
  logic [15:0] flags0_next;
  logic [15:0] flags1_next;

  wire [15:0] wmask0;
  wire [15:0] wmask1;

  assign wmask0 = (wr_done & hit_flags0) ?
                  (lane_mask[15:0] & `IFB_IMPL0) : 16'h0000;
  assign wmask1 = (wr_done & hit_flags1) ?
                  (lane_mask[15:0] & `IFB_IMPL1) : 16'h0000;

  // A request in the same cycle as a clearing write still lands
  assign flags0_next = ((flags0_reg & ~wmask0) | (dat_i[15:0] & wmask0)
                       | req0_vec) & `IFB_IMPL0;
  assign flags1_next = ((flags1_reg & ~wmask1) | (dat_i[15:0] & wmask1)
                       | req1_vec) & `IFB_IMPL1;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      flags0_reg <= `IFB_RST_FLAGS;
      flags1_reg <= `IFB_RST_FLAGS;
    end else begin
      flags0_reg <= flags0_next;
      flags1_reg <= flags1_next;
    end
  end

  assign flags = {flags1_reg, flags0_reg};

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt status and mask

  logic [31:0] stat_reg;
  logic [31:0] stat_next;
  logic [31:0] mask_reg;
  logic [31:0] mask_next;

  wire [31:0] stat_clr;

  // Only bits actually returned are cleared, so a late event survives
  assign stat_clr = (rd_done & hit_stat) ? dat_reg : 32'h0000_0000;
  assign stat_next = (stat_reg & ~stat_clr) | req_all;
  assign mask_next = (wr_done & hit_mask) ?
                     ((mask_reg & ~lane_mask) | (dat_i & lane_mask)
                      & {`IFB_IMPL1, `IFB_IMPL0}) : mask_reg;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      stat_reg <= `IFB_RST_STAT;
      mask_reg <= `IFB_RST_MASK;
    end else begin
      stat_reg <= stat_next;
      mask_reg <= mask_next;
    end
  end

  assign irq = |(stat_reg & mask_reg);

  ////////////////////////////////////////////////////////////////////////////
  // Bus answer

  // Read data is captured at the edge before ack, one wait state
  assign dat_next = hit_flags0 ? {16'h0000, flags0_reg} :
                    hit_flags1 ? {16'h0000, flags1_reg} :
                    hit_stat ? stat_reg :
                    hit_mask ? mask_reg : 32'h0000_0000;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ack_reg <= 1'b0;
      dat_reg <= 32'h0000_0000;
    end else begin
      ack_reg <= req_live & ~ack_reg;
      if (req_live & ~ack_reg) begin
        dat_reg <= dat_next;
      end
    end
  end

  assign ack_o = ack_reg;
  assign dat_o = dat_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  property p_rsvd0_zero;
    @(posedge sys_clk) disable iff (!rst_n)
      flags0_reg[`IFB_BIT_RSVD0] == 1'b0;
  endproperty
  a_rsvd0_zero: assert property (p_rsvd0_zero)
    else $error("bank 0 reserved bit set");

  property p_rsvd1_zero;
    @(posedge sys_clk) disable iff (!rst_n)
      flags1_reg[`IFB_BIT_RSVD1] == 1'b0 && stat_reg[21] == 1'b0;
  endproperty
  a_rsvd1_zero: assert property (p_rsvd1_zero)
    else $error("bank 1 reserved bit set");

  property p_req_sets0;
    @(posedge sys_clk) disable iff (!rst_n)
      |req0_vec |=> ((flags0_reg & $past(req0_vec)) == $past(req0_vec));
  endproperty
  a_req_sets0: assert property (p_req_sets0)
    else $error("bank 0 request did not set its flag");

  property p_req_sets1;
    @(posedge sys_clk) disable iff (!rst_n)
      |req1_vec |=> ((flags1_reg & $past(req1_vec)) == $past(req1_vec));
  endproperty
  a_req_sets1: assert property (p_req_sets1)
    else $error("bank 1 request did not set its flag");

  property p_ext_pin_b_pos;
    @(posedge sys_clk) disable iff (!rst_n)
      req1.ext_pin_b_flag |=> flags1_reg[4];
  endproperty
  a_ext_pin_b_pos: assert property (p_ext_pin_b_pos)
    else $error("pin B request not at bit 4");

  property p_no_spurious;
    @(posedge sys_clk) disable iff (!rst_n)
      (req0_vec == 16'h0000 && !(wr_done && hit_flags0))
        |=> (flags0_reg & ~$past(flags0_reg)) == 16'h0000;
  endproperty
  a_no_spurious: assert property (p_no_spurious)
    else $error("flag rose with no request or write");

  property p_write_stores;
    @(posedge sys_clk) disable iff (!rst_n)
      (wr_done && hit_flags1 && sel_i[1:0] == 2'h3)
        |=> flags1_reg == (($past(dat_i[15:0]) | $past(req1_vec))
                           & `IFB_IMPL1);
  endproperty
  a_write_stores: assert property (p_write_stores)
    else $error("bank 1 write not stored");

  property p_ack_one;
    @(posedge sys_clk) disable iff (!rst_n)
      (req_live && !ack_o) |=> ack_o ##1 !ack_o;
  endproperty
  a_ack_one: assert property (p_ack_one)
    else $error("ack not a single cycle after one wait");

  property p_read_flags0;
    @(posedge sys_clk) disable iff (!rst_n)
      (ack_o && !we_i && hit_flags0)
        |-> dat_o == {16'h0000, $past(flags0_reg)};
  endproperty
  a_read_flags0: assert property (p_read_flags0)
    else $error("bank 0 read data wrong");

  property p_irq_level;
    @(posedge sys_clk) disable iff (!rst_n)
      (stat_reg[0] && mask_reg[0]) |-> irq;
  endproperty
  a_irq_level: assert property (p_irq_level)
    else $error("interrupt low with pending unmasked event");

  property p_rdclr;
    @(posedge sys_clk) disable iff (!rst_n)
      (rd_done && hit_stat && req_all == 32'h0000_0000)
        |=> (stat_reg & $past(dat_reg)) == 32'h0000_0000;
  endproperty
  a_rdclr: assert property (p_rdclr)
    else $error("status read did not clear");

  property p_read_flags1;
    @(posedge sys_clk) disable iff (!rst_n)
      (ack_o && !we_i && hit_flags1)
        |-> dat_o == {16'h0000, $past(flags1_reg)};
  endproperty
  a_read_flags1: assert property (p_read_flags1)
    else $error("bank 1 read data wrong");

  property p_read_stat;
    @(posedge sys_clk) disable iff (!rst_n)
      (ack_o && !we_i && hit_stat)
        |-> dat_o == $past(stat_reg);
  endproperty
  a_read_stat: assert property (p_read_stat)
    else $error("status read data wrong");

  property p_read_mask;
    @(posedge sys_clk) disable iff (!rst_n)
      (ack_o && !we_i && hit_mask)
        |-> dat_o == $past(mask_reg);
  endproperty
  a_read_mask: assert property (p_read_mask)
    else $error("mask read data wrong");

  property p_read_unmapped;
    @(posedge sys_clk) disable iff (!rst_n)
      (ack_o && !we_i && !(hit_flags0 || hit_flags1 || hit_stat || hit_mask))
        |-> dat_o == 32'h0000_0000;
  endproperty
  a_read_unmapped: assert property (p_read_unmapped)
    else $error("unmapped read not zero");

  property p_write_stores0;
    @(posedge sys_clk) disable iff (!rst_n)
      (wr_done && hit_flags0 && sel_i[1:0] == 2'h3)
        |=> flags0_reg == (($past(dat_i[15:0]) | $past(req0_vec))
                           & `IFB_IMPL0);
  endproperty
  a_write_stores0: assert property (p_write_stores0)
    else $error("bank 0 write not stored");

  // Byte lanes left out of a write must keep their flags
  property p_part_keep;
    @(posedge sys_clk) disable iff (!rst_n)
      (wr_done && hit_flags1 && sel_i[1:0] == 2'h1)
        |=> flags1_reg[15:8] == ($past(flags1_reg[15:8])
                                 | $past(req1_vec[15:8]));
  endproperty
  a_part_keep: assert property (p_part_keep)
    else $error("bank 1 unselected byte changed");

  property p_mask_hold;
    @(posedge sys_clk) disable iff (!rst_n)
      !(wr_done && hit_mask) |=> mask_reg == $past(mask_reg);
  endproperty
  a_mask_hold: assert property (p_mask_hold)
    else $error("mask changed without a mask write");

  property p_stat_sticky;
    @(posedge sys_clk) disable iff (!rst_n)
      !(rd_done && hit_stat)
        |=> (stat_reg & $past(stat_reg)) == $past(stat_reg);
  endproperty
  a_stat_sticky: assert property (p_stat_sticky)
    else $error("status bit lost without a status read");

  property p_ack_needs_req;
    @(posedge sys_clk) disable iff (!rst_n)
      ack_o |-> $past(req_live);
  endproperty
  a_ack_needs_req: assert property (p_ack_needs_req)
    else $error("ack without a request");

  c_write_flag: cover property (@(posedge sys_clk) disable iff (!rst_n)
    wr_done && hit_flags0);
  c_set_vs_clear: cover property (@(posedge sys_clk) disable iff (!rst_n)
    wr_done && hit_flags1 && |req1_vec);
  c_irq: cover property (@(posedge sys_clk) disable iff (!rst_n)
    $rose(irq));
  c_stat_clear: cover property (@(posedge sys_clk) disable iff (!rst_n)
    rd_done && hit_stat);

endmodule

// >>> verification/ifb_periph_model.sv
`timescale 1ns/1ps

// Peripherals raising request lines; lines idle low between requests
module ifb_periph_model (
  input wire logic sys_clk, // System clock
  output ifb_pkg::ifb_req0_t req0, // Bank 0 request lines
  output ifb_pkg::ifb_req1_t req1 // Bank 1 request lines
);
  initial begin
    req0 = '0;
    req1 = '0;
  end

  // One-cycle request, {bank1,bank0}; reserved bits may be raised on purpose
  task automatic pulse(input logic [31:0] v);
    @(posedge sys_clk);
    req0 <= v[15:0];
    req1 <= v[31:16];
    @(posedge sys_clk);
    req0 <= '0;
    req1 <= '0;
  endtask
endmodule

// >>> verification/tb_ifb_flag_bank.sv
`timescale 1ns/1ps
`include "ifb_regs.svh"

module tb_ifb_flag_bank;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'h0;
  logic [31:0] wdat = 32'h0000_0000;
  logic [31:0] dat_o;
  logic [31:0] rdat;
  logic [31:0] exp;
  logic [7:0] ofs;
  logic ack_o;
  logic irq;
  logic [3:0] bsel = 4'hF;
  ifb_pkg::ifb_req0_t req0;
  ifb_pkg::ifb_req1_t req1;
  ifb_pkg::ifb_flags_t flags;
  int num_errors = 0;
  int comparisons = 0;
  int cycles = 0;

  always #12.5 sys_clk = ~sys_clk;

  ifb_periph_model per (.sys_clk(sys_clk), .req0(req0), .req1(req1));

  ifb_flag_bank dut (
    .sys_clk(sys_clk), .rst_n(rst_n), .req0(req0), .req1(req1),
    .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(sel),
    .dat_i(wdat), .dat_o(dat_o), .ack_o(ack_o), .flags(flags),
    .irq(irq)
  );

  task automatic end_of_test();
    if (num_errors == 0 && comparisons > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] want);
    comparisons++;
    if (got !== want) begin
      num_errors++;
      $display("ERROR %0t got %h want %h", $time, got, want);
    end
  endtask

  // Classic cycle; request held until the edge that samples ack
  task automatic wb(input logic w, input logic [7:0] a,
                    input logic [31:0] d, output logic [31:0] q);
    @(posedge sys_clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= bsel;
    do @(posedge sys_clk); while (ack_o !== 1'b1);
    q = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask

  // Ceiling well above the few hundred cycles the tests need
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      end_of_test();
    end
  end

  initial begin
    repeat (20) @(posedge sys_clk);
    rst_n <= 1'b1;
    check(flags, 32'h0000_0000);
    wb(1'b0, `IFB_OFS_FLAGS0, 32'h0, rdat);
    check(rdat, 32'h0000_0000);
    wb(1'b0, `IFB_OFS_FLAGS1, 32'h0, rdat);
    check(rdat, 32'h0000_0000);
    wb(1'b0, `IFB_OFS_MASK, 32'h0, rdat);
    check(rdat, 32'h0000_0000);
    for (int i = 0; i < 32; i++) begin
      ofs = (i < 16) ? `IFB_OFS_FLAGS0 : `IFB_OFS_FLAGS1;
      exp = (32'h1 << i) & {`IFB_IMPL1, `IFB_IMPL0};
      per.pulse(32'h1 << i);
      @(negedge sys_clk);
      check(flags, exp);
      wb(1'b0, ofs, 32'h0, rdat);
      check(rdat, {16'h0000, ((i < 16) ? exp[15:0] : exp[31:16])});
      wb(1'b1, ofs, 32'h0, rdat);
      @(negedge sys_clk);
      check(flags, 32'h0000_0000);
    end
    // Status is sticky and cleared by its own read
    wb(1'b0, `IFB_OFS_STAT, 32'h0, rdat);
    check(rdat, {`IFB_IMPL1, `IFB_IMPL0});
    wb(1'b0, `IFB_OFS_STAT, 32'h0, rdat);
    check(rdat, 32'h0000_0000);
    wb(1'b1, `IFB_OFS_MASK, 32'h0000_0001, rdat);
    wb(1'b0, `IFB_OFS_MASK, 32'h0, rdat);
    check(rdat, 32'h0000_0001);
    per.pulse(32'h0000_0002);
    @(negedge sys_clk);
    check({31'h0, irq}, 32'h0000_0000);
    per.pulse(32'h0000_0001);
    @(negedge sys_clk);
    check({31'h0, irq}, 32'h0000_0001);
    wb(1'b0, `IFB_OFS_STAT, 32'h0, rdat);
    check(rdat, 32'h0000_0003);
    @(negedge sys_clk);
    check({31'h0, irq}, 32'h0000_0000);
    check(flags, 32'h0000_0003);
    // Forced set through writes; unused positions stay zero
    wb(1'b1, `IFB_OFS_FLAGS0, 32'hFFFF_FFFF, rdat);
    wb(1'b0, `IFB_OFS_FLAGS0, 32'h0, rdat);
    check(rdat, {16'h0000, `IFB_IMPL0});
    wb(1'b1, `IFB_OFS_FLAGS1, 32'hFFFF_FFFF, rdat);
    wb(1'b0, `IFB_OFS_FLAGS1, 32'h0, rdat);
    check(rdat, {16'h0000, `IFB_IMPL1});
    // Low byte lane only; the high byte keeps its flags
    bsel = 4'h1;
    wb(1'b1, `IFB_OFS_FLAGS1, 32'h0, rdat);
    bsel = 4'hF;
    wb(1'b0, `IFB_OFS_FLAGS1, 32'h0, rdat);
    check(rdat, 32'h0000_FF00);
    // Request on the very edge of a clearing write: the set wins
    fork
      wb(1'b1, `IFB_OFS_FLAGS1, 32'h0, rdat);
      begin
        @(posedge sys_clk);
        per.pulse(32'h0001_0000);
      end
    join
    @(negedge sys_clk);
    check(flags, {16'h0001, `IFB_IMPL0});
    wb(1'b1, 8'h10, 32'hFFFF_FFFF, rdat);
    wb(1'b0, 8'h10, 32'h0, rdat);
    check(rdat, 32'h0000_0000);
    check(flags, {16'h0001, `IFB_IMPL0});
    // Mid-run reset clears flags, status and mask
    @(posedge sys_clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(negedge sys_clk);
    check(flags, 32'h0000_0000);
    wb(1'b0, `IFB_OFS_STAT, 32'h0, rdat);
    check(rdat, 32'h0000_0000);
    wb(1'b0, `IFB_OFS_MASK, 32'h0, rdat);
    check(rdat, 32'h0000_0000);
    end_of_test();
  end
endmodule
